// ---- verilog/wire_cmd_pkg.sv ----
// constants and types shared by the wire command decoder
// Summary of operation
// - method value 1 selects two-wire method 3
// - two-wire: one input runs, both/none stop
// - two-wire direction change accepted any time
// - method value 2 selects three-wire method 1
// - three-wire 1: enable low forces ramp-stop
// - forward rising edge, reverse low: run forward
// - reverse rising edge, forward low: run backward
// - both low hold, both high ramp-stop
// - method value 3 selects three-wire method 2
// - standstill start edge runs per direction level
// - rotating: direction edges reverse the motor; the code does so only while start is low
// - enable low stops only while rotating
// - ignore start when rotating, direction at standstill
// - any input takes any function code
// - three-wire 1 defaults: codes 1, 2, 12
// - three-wire 2 defaults: codes 2, 1, 12
// - decode command source values 0,1,2,4,5,6
// - source resets to fieldbus or digital inputs
// - decoders act only with digital input source
// - code 12 reverse, 1 on/stop, 2 forward
package wire_cmd_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int FUNC_W = 7;
   localparam int METHOD_W = 2;
   localparam int SRC_W = 3;
   localparam int NUM_FUNC_INPUTS = 4;
   localparam int SYNC_STAGES = 2;

   // ----------------------------------------------------------------
   // wiring method settings
   // ----------------------------------------------------------------
   localparam logic [METHOD_W-1:0] METHOD_FACTORY = 2'h0;
   localparam logic [METHOD_W-1:0] METHOD_TWO_WIRE_3 = 2'h1;
   localparam logic [METHOD_W-1:0] METHOD_THREE_WIRE_1 = 2'h2;
   localparam logic [METHOD_W-1:0] METHOD_THREE_WIRE_2 = 2'h3;

   // ----------------------------------------------------------------
   // command source settings
   // ----------------------------------------------------------------
   localparam logic [SRC_W-1:0] SRC_FACTORY = 3'h0;
   localparam logic [SRC_W-1:0] SRC_PANEL = 3'h1;
   localparam logic [SRC_W-1:0] SRC_DIGITAL = 3'h2;
   localparam logic [SRC_W-1:0] SRC_SERIAL_232 = 3'h4;
   localparam logic [SRC_W-1:0] SRC_SERIAL_485 = 3'h5;
   localparam logic [SRC_W-1:0] SRC_FIELDBUS = 3'h6;

   // ----------------------------------------------------------------
   // input function codes
   // ----------------------------------------------------------------
   localparam logic [FUNC_W-1:0] CODE_DISABLED = 7'h00;
   localparam logic [FUNC_W-1:0] CODE_ON_STOP = 7'h01;
   localparam logic [FUNC_W-1:0] CODE_FORWARD = 7'h02;
   localparam logic [FUNC_W-1:0] CODE_REVERSE = 7'h0c;

   // ----------------------------------------------------------------
   // default input mappings per method
   // ----------------------------------------------------------------
   localparam logic [FUNC_W-1:0] TW1_FUNC0 = CODE_ON_STOP;
   localparam logic [FUNC_W-1:0] TW1_FUNC1 = CODE_FORWARD;
   localparam logic [FUNC_W-1:0] TW1_FUNC2 = CODE_REVERSE;
   localparam logic [FUNC_W-1:0] TW1_FUNC3 = CODE_DISABLED;
   localparam logic [FUNC_W-1:0] TW2_FUNC0 = CODE_FORWARD;
   localparam logic [FUNC_W-1:0] TW2_FUNC1 = CODE_ON_STOP;
   localparam logic [FUNC_W-1:0] TW2_FUNC2 = CODE_REVERSE;
   localparam logic [FUNC_W-1:0] TW2_FUNC3 = CODE_DISABLED;

   typedef enum logic [1:0] {
      MOTION_STOP,
      MOTION_FWD,
      MOTION_REV
   } motion_t;

endpackage : wire_cmd_pkg

// ---- verilog/input_edge_sync.sv ----
// synchroniser and previous-sample stage for the digital inputs
`timescale 1ns/100ps
module input_edge_sync #(
   parameter int N = 4
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [N-1:0] din,
   output logic [N-1:0] level,
   output logic [N-1:0] level_prev
);

   // ----------------------------------------------------------------
   // per-input two stage synchroniser plus history flop
   // ----------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_bit
         logic meta_reg;
         logic sync_reg;
         logic prev_reg;
         // the first stage feeds only the second one
         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               meta_reg <= 1'b0;
               sync_reg <= 1'b0;
               prev_reg <= 1'b0;
            end else begin
               meta_reg <= din[i];
               sync_reg <= meta_reg;
               prev_reg <= sync_reg;
            end
         end
         assign level[i] = sync_reg;
         assign level_prev[i] = prev_reg;
      end
   endgenerate

endmodule : input_edge_sync

// ---- verilog/motor_wire_command_decoder.sv ----
// wire method command decoder for motor run, direction and ramp-stop
`timescale 1ns/100ps
module motor_wire_command_decoder #(
   parameter int NUM_INPUTS = wire_cmd_pkg::NUM_FUNC_INPUTS,
   parameter bit HAS_FIELDBUS = 1'b1
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [NUM_INPUTS-1:0] din,
   input wire logic [wire_cmd_pkg::METHOD_W-1:0] wiring_method_select,
   input wire logic source_write,
   input wire logic [wire_cmd_pkg::SRC_W-1:0] source_wdata,
   input wire logic function_write,
   input wire logic [$clog2(NUM_INPUTS)-1:0] function_index,
   input wire logic [wire_cmd_pkg::FUNC_W-1:0] function_wdata,
   input wire logic defaults_load,
   input wire logic motor_standstill,
   output logic [wire_cmd_pkg::SRC_W-1:0] command_source_select,
   output logic [NUM_INPUTS*wire_cmd_pkg::FUNC_W-1:0] input_functions,
   output logic factory_source,
   output logic operator_panel_source,
   output logic digital_source,
   output logic serial232_source,
   output logic serial485_source,
   output logic fieldbus_source,
   output logic decoder_active,
   output logic forward_run,
   output logic backward_run,
   output logic ramp_stop,
   output logic function_missing
);

   localparam int FW = wire_cmd_pkg::FUNC_W;
   localparam int IW = $clog2(NUM_INPUTS);
   localparam logic [wire_cmd_pkg::SRC_W-1:0] SRC_RESET =
      HAS_FIELDBUS ? wire_cmd_pkg::SRC_FIELDBUS
                   : wire_cmd_pkg::SRC_DIGITAL;

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic [wire_cmd_pkg::SYNC_STAGES-1:0] rst_pipe_reg;
   logic rst_n;

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rst_pipe_reg <= '0;
      end else begin
         rst_pipe_reg <= {rst_pipe_reg[wire_cmd_pkg::SYNC_STAGES-2:0],
                          1'b1};
      end
   end
   assign rst_n = rst_pipe_reg[wire_cmd_pkg::SYNC_STAGES-1];

   // ----------------------------------------------------------------
   // command source setting
   // ----------------------------------------------------------------
   logic [wire_cmd_pkg::SRC_W-1:0] source_reg;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         source_reg <= SRC_RESET;
      end else if (source_write) begin
         source_reg <= source_wdata;
      end
   end

   assign command_source_select = source_reg;
   // unlisted values select nothing, so no source drives the motor
   assign factory_source =
      (source_reg == wire_cmd_pkg::SRC_FACTORY);
   assign operator_panel_source =
      (source_reg == wire_cmd_pkg::SRC_PANEL);
   assign digital_source =
      (source_reg == wire_cmd_pkg::SRC_DIGITAL);
   assign serial232_source =
      (source_reg == wire_cmd_pkg::SRC_SERIAL_232);
   assign serial485_source =
      (source_reg == wire_cmd_pkg::SRC_SERIAL_485);
   assign fieldbus_source =
      (source_reg == wire_cmd_pkg::SRC_FIELDBUS);

   // ----------------------------------------------------------------
   // per-input function settings and code matching
   // ----------------------------------------------------------------
   logic [NUM_INPUTS-1:0] lvl;
   logic [NUM_INPUTS-1:0] lvl_prev;
   logic [NUM_INPUTS-1:0] match_on;
   logic [NUM_INPUTS-1:0] match_fwd;
   logic [NUM_INPUTS-1:0] match_rev;
   logic three_wire_2_sel;

   assign three_wire_2_sel =
      (wiring_method_select == wire_cmd_pkg::METHOD_THREE_WIRE_2);

   input_edge_sync #(
      .N(NUM_INPUTS)
   ) u_sync (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .din(din),
      .level(lvl),
      .level_prev(lvl_prev)
   );

   genvar i;
   generate
      for (i = 0; i < NUM_INPUTS; i++) begin : g_func
         logic [FW-1:0] func_reg;
         logic [FW-1:0] def_tw1;
         logic [FW-1:0] def_tw2;
         always_comb begin
            case (i)
               0: begin
                  def_tw1 = wire_cmd_pkg::TW1_FUNC0;
                  def_tw2 = wire_cmd_pkg::TW2_FUNC0;
               end
               1: begin
                  def_tw1 = wire_cmd_pkg::TW1_FUNC1;
                  def_tw2 = wire_cmd_pkg::TW2_FUNC1;
               end
               2: begin
                  def_tw1 = wire_cmd_pkg::TW1_FUNC2;
                  def_tw2 = wire_cmd_pkg::TW2_FUNC2;
               end
               3: begin
                  def_tw1 = wire_cmd_pkg::TW1_FUNC3;
                  def_tw2 = wire_cmd_pkg::TW2_FUNC3;
               end
               default: begin
                  def_tw1 = wire_cmd_pkg::CODE_DISABLED;
                  def_tw2 = wire_cmd_pkg::CODE_DISABLED;
               end
            endcase
         end
         // an explicit write beats a defaults reload in the same cycle
         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               func_reg <= (i == 0) ? wire_cmd_pkg::TW1_FUNC0 :
                           (i == 1) ? wire_cmd_pkg::TW1_FUNC1 :
                           (i == 2) ? wire_cmd_pkg::TW1_FUNC2 :
                           wire_cmd_pkg::CODE_DISABLED;
            end else if (function_write &&
                         function_index == IW'(i)) begin
               func_reg <= function_wdata;
            end else if (defaults_load) begin
               func_reg <= three_wire_2_sel ? def_tw2 : def_tw1;
            end
         end
         assign input_functions[i*FW +: FW] = func_reg;
         assign match_on[i] =
            (func_reg == wire_cmd_pkg::CODE_ON_STOP);
         assign match_fwd[i] =
            (func_reg == wire_cmd_pkg::CODE_FORWARD);
         assign match_rev[i] =
            (func_reg == wire_cmd_pkg::CODE_REVERSE);
      end
   endgenerate

   // ----------------------------------------------------------------
   // decoded command levels and edges
   // ----------------------------------------------------------------
   // several inputs with one code act as a wired OR
   logic on_lvl, on_prev, fwd_lvl, fwd_prev, rev_lvl, rev_prev;

   assign on_lvl = |(lvl & match_on);
   assign on_prev = |(lvl_prev & match_on);
   assign fwd_lvl = |(lvl & match_fwd);
   assign fwd_prev = |(lvl_prev & match_fwd);
   assign rev_lvl = |(lvl & match_rev);
   assign rev_prev = |(lvl_prev & match_rev);

   logic on_rise, fwd_rise, rev_rise, rev_fall;

   assign on_rise = on_lvl & ~on_prev;
   assign fwd_rise = fwd_lvl & ~fwd_prev;
   assign rev_rise = rev_lvl & ~rev_prev;
   assign rev_fall = ~rev_lvl & rev_prev;

   // ----------------------------------------------------------------
   // method decode
   // ----------------------------------------------------------------
   wire_cmd_pkg::motion_t state_reg, state_next;
   logic [wire_cmd_pkg::METHOD_W-1:0] method_prev_reg;
   logic active;
   logic method_known;

   assign method_known =
      (wiring_method_select != wire_cmd_pkg::METHOD_FACTORY);
   assign active = digital_source && method_known;

   always_comb begin
      state_next = state_reg;
      if (!active || wiring_method_select != method_prev_reg) begin
         // a method change mid-run stops rather than reinterpreting
         state_next = wire_cmd_pkg::MOTION_STOP;
      end else begin
         case (wiring_method_select)
            wire_cmd_pkg::METHOD_TWO_WIRE_3: begin
               // levels only, so a reversal applies at once
               if (on_lvl && !fwd_lvl) begin
                  state_next = wire_cmd_pkg::MOTION_FWD;
               end else if (fwd_lvl && !on_lvl) begin
                  state_next = wire_cmd_pkg::MOTION_REV;
               end else begin
                  state_next = wire_cmd_pkg::MOTION_STOP;
               end
            end
            wire_cmd_pkg::METHOD_THREE_WIRE_1: begin
               if (!on_lvl) begin
                  state_next = wire_cmd_pkg::MOTION_STOP;
               end else if (fwd_lvl && rev_lvl) begin
                  state_next = wire_cmd_pkg::MOTION_STOP;
               end else if (fwd_rise && !rev_lvl) begin
                  state_next = wire_cmd_pkg::MOTION_FWD;
               end else if (rev_rise && !fwd_lvl) begin
                  state_next = wire_cmd_pkg::MOTION_REV;
               end else begin
                  state_next = state_reg;
               end
            end
            wire_cmd_pkg::METHOD_THREE_WIRE_2: begin
               if (motor_standstill) begin
                  // direction edges and low enable do nothing here
                  if (fwd_lvl && on_rise) begin
                     state_next = rev_lvl ? wire_cmd_pkg::MOTION_REV
                                          : wire_cmd_pkg::MOTION_FWD;
                  end
               end else if (!fwd_lvl) begin
                  state_next = wire_cmd_pkg::MOTION_STOP;
               end else if (!on_lvl &&
                            state_reg != wire_cmd_pkg::MOTION_STOP) begin
                  // start edges are not looked at while rotating
                  if (rev_rise) begin
                     state_next = wire_cmd_pkg::MOTION_REV;
                  end else if (rev_fall) begin
                     state_next = wire_cmd_pkg::MOTION_FWD;
                  end
               end
            end
            default: begin
               state_next = wire_cmd_pkg::MOTION_STOP;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // motion state
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= wire_cmd_pkg::MOTION_STOP;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         method_prev_reg <= wire_cmd_pkg::METHOD_FACTORY;
      end else begin
         method_prev_reg <= wiring_method_select;
      end
   end

   // ----------------------------------------------------------------
   // registered command outputs
   // ----------------------------------------------------------------
   logic active_reg, fwd_reg, bwd_reg, stop_reg, missing_reg;
   logic missing_next;

   always_comb begin
      case (wiring_method_select)
         wire_cmd_pkg::METHOD_TWO_WIRE_3: begin
            missing_next = !(|match_on) || !(|match_fwd);
         end
         wire_cmd_pkg::METHOD_THREE_WIRE_1,
         wire_cmd_pkg::METHOD_THREE_WIRE_2: begin
            missing_next = !(|match_on) || !(|match_fwd) ||
                           !(|match_rev);
         end
         default: begin
            missing_next = 1'b0;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         active_reg <= 1'b0;
         fwd_reg <= 1'b0;
         bwd_reg <= 1'b0;
         stop_reg <= 1'b0;
      end else begin
         // another source owns the motor when this one is inactive
         active_reg <= active;
         fwd_reg <= active &&
                    state_next == wire_cmd_pkg::MOTION_FWD;
         bwd_reg <= active &&
                    state_next == wire_cmd_pkg::MOTION_REV;
         stop_reg <= active &&
                     state_next == wire_cmd_pkg::MOTION_STOP;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         missing_reg <= 1'b0;
      end else begin
         missing_reg <= missing_next;
      end
   end

   assign decoder_active = active_reg;
   assign forward_run = fwd_reg;
   assign backward_run = bwd_reg;
   assign ramp_stop = stop_reg;
   assign function_missing = missing_reg;

endmodule : motor_wire_command_decoder

// ---- tb/switch_bank_model.sv ----
// switch bank and motor core standstill flag at the decoder's far side
`timescale 1ns/100ps
module switch_bank_model (
   input wire logic ref_clk,
   input wire logic [3:0] want,
   input wire logic want_still,
   output logic [3:0] din,
   output logic motor_standstill
);
   logic [3:0] want_q = 4'h0;
   logic still_q = 1'b1;
   initial begin
      din = 4'h0;
      motor_standstill = 1'b1;
   end
   // requests are taken half a cycle after the bench moved them, so the
   // falling-edge update below never races the bench's own falling edge
   always @(posedge ref_clk) begin
      want_q <= want;
      still_q <= want_still;
   end
   // contacts move only between rising edges, so no sample sees a change
   always @(negedge ref_clk) begin
      din <= want_q;
      motor_standstill <= still_q;
   end
endmodule : switch_bank_model

// ---- tb/motor_wire_command_decoder_chk.sv ----
// concurrent checks on the wire command decoder ports
`timescale 1ns/100ps
module motor_wire_command_decoder_chk #(
   parameter int NUM_INPUTS = 4
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [NUM_INPUTS-1:0] din,
   input wire logic [1:0] wiring_method_select,
   input wire logic source_write,
   input wire logic [2:0] source_wdata,
   input wire logic function_write,
   input wire logic [$clog2(NUM_INPUTS)-1:0] function_index,
   input wire logic [6:0] function_wdata,
   input wire logic [2:0] command_source_select,
   input wire logic [NUM_INPUTS*7-1:0] input_functions,
   input wire logic factory_source,
   input wire logic operator_panel_source,
   input wire logic digital_source,
   input wire logic serial232_source,
   input wire logic serial485_source,
   input wire logic fieldbus_source,
   input wire logic decoder_active,
   input wire logic forward_run,
   input wire logic backward_run,
   input wire logic ramp_stop
);
   // ----------------------------------------------------------------
   // helper logic
   // ----------------------------------------------------------------
   logic [$clog2(NUM_INPUTS)-1:0] idx_q;
   logic [6:0] code_q;
   logic want_active;
   logic maps_m1;
   logic [2:0] cmds;
   logic [2:0] sel;
   always_ff @(posedge ref_clk) begin
      idx_q <= function_index;
      code_q <= function_wdata;
   end
   assign sel = command_source_select;
   assign want_active = sel == 3'h2 && wiring_method_select != 2'h0;
   assign maps_m1 = input_functions == {7'h00, 7'h0c, 7'h02, 7'h01};
   assign cmds = {forward_run, backward_run, ramp_stop};

   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);

   // ----------------------------------------------------------------
   // sequences
   // ----------------------------------------------------------------
   // long enough for a level to cross synchroniser and output register
   sequence s_steady(logic [1:0] m);
      (decoder_active && maps_m1 && wiring_method_select == m &&
       $stable(din) && $stable(wiring_method_select))[*4];
   endsequence
   sequence s_m1_base;
      decoder_active && maps_m1 && wiring_method_select == 2'h2 &&
      $stable(wiring_method_select) && din[0] && $stable(din[0]);
   endsequence
   sequence s_hold3;
      (decoder_active && $stable(din) && $stable(wiring_method_select))[*3];
   endsequence

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   AST_CMD_ONEHOT: assert property (decoder_active |-> $onehot(cmds))
      else $error("exactly one command expected while decoding");
   AST_CMD_QUIET: assert property (!decoder_active |-> cmds == 3'h0)
      else $error("commands driven while decoder inactive");
   AST_ACTIVE: assert property (decoder_active == $past(want_active))
      else $error("decoder activity does not follow source and method");
   AST_SRC_FLAGS: assert property ({factory_source, operator_panel_source,
      digital_source, serial232_source, serial485_source, fieldbus_source}
      == {sel == 3'h0, sel == 3'h1, sel == 3'h2, sel == 3'h4, sel == 3'h5,
      sel == 3'h6})
      else $error("source flags disagree with source value");
   AST_SRC_WRITE: assert property (source_write |=>
      sel == $past(source_wdata))
      else $error("source write not taken");
   AST_FUNC_WRITE: assert property (function_write |=>
      input_functions[idx_q*7 +: 7] == code_q)
      else $error("function write not taken");
   AST_TWO_WIRE: assert property (s_steady(2'h1) |->
      forward_run == (din[1:0] == 2'b01) && backward_run == (din[1:0] == 2'b10))
      else $error("two-wire level decode wrong");
   AST_ENABLE_LOW: assert property ((s_steady(2'h2) ##0 !din[0])
      |-> ramp_stop)
      else $error("enable low did not stop");
   AST_BOTH_HIGH: assert property ((s_steady(2'h2) ##0 din[2:0] == 3'h7)
      |-> ramp_stop)
      else $error("both direction inputs high did not stop");
   AST_FWD_EDGE: assert property ((s_m1_base ##0 $rose(din[1]) && !din[2]
      && $stable(din[2]) ##1 s_hold3) |-> forward_run)
      else $error("forward edge did not run forward");
   AST_REV_EDGE: assert property ((s_m1_base ##0 $rose(din[2]) && !din[1]
      && $stable(din[1]) ##1 s_hold3) |-> backward_run)
      else $error("reverse edge did not run backward");
endmodule : motor_wire_command_decoder_chk

bind motor_wire_command_decoder motor_wire_command_decoder_chk #(
   .NUM_INPUTS(NUM_INPUTS)
) chk_i (.*);

// ---- tb/test_motor_wire_command_decoder.sv ----
// self-checking bench for the wire command decoder
`timescale 1ns/100ps
module test_motor_wire_command_decoder;
   typedef struct packed {
      logic ld;
      logic [1:0] m;
      logic [3:0] d;
      logic s;
      logic [2:0] e;
   } row_t;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic [3:0] want = 4'h0;
   logic want_still = 1'b1;
   logic [3:0] din;
   logic motor_standstill;
   logic [1:0] wiring_method_select = 2'h1;
   logic source_write = 1'b0;
   logic [2:0] source_wdata = 3'h0;
   logic function_write = 1'b0;
   logic [1:0] function_index = 2'h0;
   logic [6:0] function_wdata = 7'h00;
   logic defaults_load = 1'b0;
   logic [2:0] command_source_select;
   logic [27:0] input_functions;
   logic factory_source, operator_panel_source, digital_source;
   logic serial232_source, serial485_source, fieldbus_source;
   logic decoder_active, forward_run, backward_run, ramp_stop;
   logic function_missing;
   int error_cnt = 0;
   int samples_checked = 0;
   // ld, method, inputs, standstill, expected {forward, backward, stop}
   row_t rows [26] = '{
      '{0,1,0,1,1}, '{0,1,1,1,4}, '{0,1,2,1,2}, '{0,1,3,1,1}, '{0,1,2,1,2},
      '{0,1,1,1,4}, '{0,2,0,1,1}, '{0,2,1,1,1}, '{0,2,3,1,4}, '{0,2,1,1,4},
      '{0,2,5,1,2}, '{0,2,4,1,1}, '{0,2,6,1,1}, '{0,2,7,1,1}, '{1,3,0,1,1},
      '{0,3,1,1,1}, '{0,3,3,1,4}, '{0,3,1,0,4}, '{0,3,5,0,2}, '{0,3,7,0,2},
      '{0,3,5,0,2}, '{0,3,1,0,4}, '{0,3,0,0,1}, '{0,3,5,1,1}, '{0,3,7,1,2},
      '{0,3,6,1,2}};

   initial begin
      forever #10 ref_clk = ~ref_clk;
   end

   switch_bank_model partner (.ref_clk, .want, .want_still, .din,
      .motor_standstill);
   motor_wire_command_decoder dut (.ref_clk, .resetn, .din,
      .wiring_method_select, .source_write, .source_wdata, .function_write,
      .function_index, .function_wdata, .defaults_load, .motor_standstill,
      .command_source_select, .input_functions, .factory_source,
      .operator_panel_source, .digital_source, .serial232_source,
      .serial485_source, .fieldbus_source, .decoder_active, .forward_run,
      .backward_run, .ramp_stop, .function_missing);

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic check(input string nm, input logic [31:0] exp,
      input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : check

   task automatic set_src(input logic [2:0] v);
      source_wdata = v;
      source_write = 1'b1;
      @(negedge ref_clk);
      source_write = 1'b0;
   endtask : set_src

   task automatic set_fn(input logic [1:0] i, input logic [6:0] c);
      function_index = i;
      function_wdata = c;
      function_write = 1'b1;
      @(negedge ref_clk);
      function_write = 1'b0;
      // an idle edge keeps back-to-back writes as separate pulses
      @(negedge ref_clk);
   endtask : set_fn

   task automatic final_report;
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : final_report

   // ----------------------------------------------------------------
   // sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (10) @(negedge ref_clk);
      resetn = 1'b1;
      repeat (3) @(negedge ref_clk);
      set_src(3'h2);
      foreach (rows[i]) begin
         wiring_method_select = rows[i].m;
         want = rows[i].d;
         want_still = rows[i].s;
         defaults_load = rows[i].ld;
         @(negedge ref_clk);
         defaults_load = 1'b0;
         repeat (6) @(negedge ref_clk);
         check("commands", rows[i].e, {forward_run, backward_run, ramp_stop});
      end
      // remap: on/stop moved to input 3, old on/stop input disabled
      check("input_functions", 28'h003_0082, input_functions);
      wiring_method_select = 2'h1;
      set_fn(2'h3, 7'h01);
      set_fn(2'h1, 7'h00);
      want = 4'h8;
      repeat (6) @(negedge ref_clk);
      check("input_functions", 28'h023_0002, input_functions);
      check("function_missing", 1'b0, function_missing);
      check("commands", 3'h4, {forward_run, backward_run, ramp_stop});
      want = 4'h9;
      repeat (6) @(negedge ref_clk);
      check("commands", 3'h1, {forward_run, backward_run, ramp_stop});
      want = 4'h8;
      // every source value, commands only from the digital inputs
      for (int v = 0; v < 8; v++) begin
         set_src(v[2:0]);
         repeat (4) @(negedge ref_clk);
         check("source_flags", {v == 0, v == 1, v == 2, v == 4, v == 5,
            v == 6}, {factory_source, operator_panel_source, digital_source,
            serial232_source, serial485_source, fieldbus_source});
         check("decoder_active", v == 2, decoder_active);
         check("commands", v == 2 ? 3'h4 : 3'h0,
            {forward_run, backward_run, ramp_stop});
      end
      // with no on/stop code left, two-wire decoding lacks an input
      set_fn(2'h3, 7'h00);
      check("function_missing", 1'b1, function_missing);
      resetn = 1'b0;
      @(negedge ref_clk);
      check("command_source_select", 3'h6, command_source_select);
      check("input_functions", 28'h003_0101, input_functions);
      check("commands", 3'h0, {forward_run, backward_run, ramp_stop});
      resetn = 1'b1;
      repeat (3) @(negedge ref_clk);
      check("decoder_active", 1'b0, decoder_active);
      final_report();
   end

   // a hung run ends through the same report, counted as an error
   initial begin
      repeat (5000) @(posedge ref_clk);
      error_cnt++;
      final_report();
   end
endmodule : test_motor_wire_command_decoder
